// ===== hdl/wpt_cfg.svh
`ifndef WPT_CFG_SVH
`define WPT_CFG_SVH

`define WPT_IQ_W 16
`define WPT_ADR_W 16
`define WPT_SEG_W 4
`define WPT_MKR_N 4
`define WPT_DLY_W 16
`define WPT_DIV_W 8
`define WPT_KEY_W 9

// Sample period in clock cycles
`define WPT_SAMPLE_DIV 1

`define WPT_STATE_RST '0
`define WPT_SYNC_RST '0

`endif

// ===== hdl/wpt_pkg.sv
package wpt_pkg;
`include "wpt_cfg.svh"

    typedef enum logic [1:0] {
        WPT_SRC_KEY = 2'h0,
        WPT_SRC_BUS = 2'h1,
        WPT_SRC_EXT = 2'h2
    } wpt_src_e;

    typedef enum logic [1:0] {
        WPT_MODE_SINGLE = 2'h0,
        WPT_MODE_GATED  = 2'h1,
        WPT_MODE_SEG    = 2'h2,
        WPT_MODE_CONT   = 2'h3
    } wpt_mode_e;

    typedef enum logic [1:0] {
        WPT_RETRIG_OFF = 2'h0,
        WPT_RETRIG_ON  = 2'h1,
        WPT_RETRIG_IMM = 2'h2
    } wpt_single_e;

    typedef enum logic [1:0] {
        WPT_CONT_FREE  = 2'h0,
        WPT_CONT_TRIG  = 2'h1,
        WPT_CONT_RESET = 2'h2
    } wpt_cont_e;

    typedef enum logic [1:0] {
        WPT_DATA_ARB       = 2'h0,
        WPT_DATA_RT        = 2'h1,
        WPT_DATA_RT_FRAMED = 2'h2
    } wpt_data_e;

    typedef enum logic [2:0] {
        WPT_ST_IDLE  = 3'h0,
        WPT_ST_PLAY  = 3'h1,
        WPT_ST_PAUSE = 3'h3,
        WPT_ST_WAIT  = 3'h2,
        WPT_ST_DONE  = 3'h6
    } wpt_state_e;

    typedef struct packed {
        logic                   out_on;
        wpt_mode_e              mode;
        wpt_single_e            single_resp;
        wpt_cont_e              cont_resp;
        logic                   seg_cont;
        wpt_data_e              data_kind;
        wpt_src_e               src;
        logic                   ext_pin2;
        logic                   ext_pol_pos;
        logic                   gate_high;
        logic                   dly_en;
        logic [`WPT_DLY_W-1:0]  dly;
        logic [`WPT_SEG_W-1:0]  seg_last;
        logic [`WPT_MKR_N-1:0]  mkr_neg;
        logic [`WPT_MKR_N-1:0]  mkr_blank_route;
    } wpt_cfg_s;

    typedef struct packed {
        logic [`WPT_IQ_W-1:0]   i;
        logic [`WPT_IQ_W-1:0]   q;
        logic [`WPT_MKR_N-1:0]  mkr;
    } wpt_sample_s;

    typedef struct packed {
        logic [`WPT_ADR_W-1:0]  len_m1;
        logic [`WPT_MKR_N-1:0]  mkr_en;
    } wpt_seg_s;

    typedef struct packed {
        logic                   stage1;
        logic                   stage2;
    } wpt_sync_s;

    typedef struct packed {
        wpt_state_e             state;
        logic                   started;
        logic                   pend;
        logic                   playing;
        logic [`WPT_ADR_W-1:0]  off;
        logic [`WPT_SEG_W-1:0]  seg;
        logic [`WPT_DIV_W-1:0]  div;
        logic                   dly_busy;
        logic [`WPT_DLY_W-1:0]  dly_cnt;
        logic                   ext_act_q;
        logic [`WPT_KEY_W-1:0]  mode_key;
        logic [`WPT_IQ_W-1:0]   i_live;
        logic [`WPT_IQ_W-1:0]   q_live;
        logic [`WPT_MKR_N-1:0]  mkr_live;
        logic [`WPT_IQ_W-1:0]   i_out;
        logic [`WPT_IQ_W-1:0]   q_out;
        logic [`WPT_MKR_N-1:0]  evt;
        logic                   blank;
    } wpt_state_s;

endpackage : wpt_pkg

// ===== hdl/wpt_sync.sv
`timescale 1ns/1ps
`include "wpt_cfg.svh"
module wpt_sync (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic d,
    output logic      q
);
    import wpt_pkg::*;

    wpt_sync_s s;
    wpt_sync_s n;

    // First stage is read by the second only
    always_comb
    begin
        n = s;
        n.stage1 = d;
        n.stage2 = s.stage1;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            s <= `WPT_SYNC_RST;
        else
            s <= n;
    end

    assign q = s.stage2;

endmodule : wpt_sync

// ===== hdl/wpt_marker.sv
`timescale 1ns/1ps
module wpt_marker (
    input  wire logic live,
    input  wire logic neg,
    input  wire logic route,
    output logic      level,
    output logic      blank
);
    import wpt_pkg::*;

    assign level = live ^ neg;
    assign blank = route & ~level;

endmodule : wpt_marker

// ===== hdl/wpt_play_ctrl.sv
`timescale 1ns/1ps
`include "wpt_cfg.svh"
module wpt_play_ctrl #(
    parameter int SAMPLE_DIV = `WPT_SAMPLE_DIV
) (
    input  wire logic                  SYS_CLK,
    input  wire logic                  RSTN,
    input  wire wpt_pkg::wpt_cfg_s     CFG,
    input  wire logic                  WAVE_CHANGE,
    input  wire logic                  TRIG_KEY,
    input  wire logic                  TRIG_BUS,
    input  wire logic                  EXT_TRIG_IN1,
    input  wire logic                  EXT_TRIG_IN2,
    input  wire wpt_pkg::wpt_seg_s     SEG,
    input  wire wpt_pkg::wpt_sample_s  SAMPLE,
    output logic [`WPT_SEG_W-1:0]      SEG_INDEX,
    output logic [`WPT_ADR_W-1:0]      SAMPLE_ADDR,
    output logic [`WPT_IQ_W-1:0]       I_OUT,
    output logic [`WPT_IQ_W-1:0]       Q_OUT,
    output logic [`WPT_MKR_N-1:0]      EVENT_OUT,
    output logic                       RF_BLANK,
    output logic                       LEVEL_LOOP_HOLD,
    output logic                       PLAYING
);
    import wpt_pkg::*;

    localparam int DIV_LAST_I = SAMPLE_DIV - 1;
    localparam logic [`WPT_DIV_W-1:0] DIV_LAST = DIV_LAST_I[`WPT_DIV_W-1:0];

    wpt_state_s              s;
    wpt_state_s              n;
    logic                    ext1;
    logic                    ext2;
    logic                    ext_lvl;
    logic                    ext_act;
    logic                    gate_act;
    logic                    raw_trig;
    logic                    use_dly;
    logic                    trig;
    logic                    tick;
    logic                    end_seg;
    logic                    last_seg;
    logic                    end_wave;
    logic                    reselect;
    logic                    is_arb;
    logic                    is_fr;
    logic [`WPT_ADR_W-1:0]   off_nx;
    logic [`WPT_SEG_W-1:0]   seg_nx;
    logic [`WPT_KEY_W-1:0]   cfg_key;
    logic [`WPT_MKR_N-1:0]   mkr_lvl;
    logic [`WPT_MKR_N-1:0]   mkr_blk;

    wpt_sync u_sync1 (
        .clk  (SYS_CLK),
        .rstn (RSTN),
        .d    (EXT_TRIG_IN1),
        .q    (ext1)
    );
    wpt_sync u_sync2 (
        .clk  (SYS_CLK),
        .rstn (RSTN),
        .d    (EXT_TRIG_IN2),
        .q    (ext2)
    );

    assign ext_lvl = CFG.ext_pin2 ? ext2 : ext1;
    assign ext_act = CFG.ext_pol_pos ? ext_lvl : ~ext_lvl;
    assign gate_act = CFG.gate_high ? ext_lvl : ~ext_lvl;
    assign raw_trig = (CFG.src == WPT_SRC_KEY) ? TRIG_KEY :
                      (CFG.src == WPT_SRC_BUS) ? TRIG_BUS :
                      (CFG.src == WPT_SRC_EXT) ? (ext_act & s.ext_act_q) : 1'b0;
    assign use_dly = CFG.dly_en && (CFG.src == WPT_SRC_EXT);
    // delayed trigger fires at count end
    assign trig = use_dly ? (s.dly_busy && (s.dly_cnt == '0)) : raw_trig;
    assign tick = (s.div == DIV_LAST);
    assign end_seg = (s.off == SEG.len_m1);
    assign last_seg = (s.seg == CFG.seg_last);
    assign end_wave = end_seg && last_seg;
    assign off_nx = end_seg ? '0 : s.off + 1'b1;
    assign seg_nx = last_seg ? '0 : s.seg + 1'b1;
    assign is_arb = (CFG.data_kind == WPT_DATA_ARB);
    assign is_fr = (CFG.data_kind == WPT_DATA_RT_FRAMED);
    assign cfg_key = {CFG.mode, CFG.single_resp, CFG.cont_resp, CFG.seg_cont, CFG.data_kind};
    // stop on output off or new selection
    assign reselect = (cfg_key != s.mode_key) || WAVE_CHANGE || !CFG.out_on;

    genvar k;
    for (k = 0; k < `WPT_MKR_N; k++)
    begin : g_mkr
        wpt_marker u_mkr (
            .live  (s.mkr_live[k]),
            .neg   (CFG.mkr_neg[k]),
            .route (CFG.mkr_blank_route[k]),
            .level (mkr_lvl[k]),
            .blank (mkr_blk[k])
        );
    end

    always_comb
    begin
        n = s;
        n.mode_key = cfg_key;
        n.ext_act_q = ~ext_act;
        n.div = tick ? '0 : s.div + 1'b1;
        n.i_out = s.i_live;
        n.q_out = s.q_live;
        n.evt = mkr_lvl;
        n.blank = |mkr_blk;
        // triggers during the delay are dropped
        if (s.dly_busy)
        begin
            if (s.dly_cnt == '0)
                n.dly_busy = 1'b0;
            else
                n.dly_cnt = s.dly_cnt - 1'b1;
        end
        else if (raw_trig && use_dly)
        begin
            n.dly_busy = 1'b1;
            n.dly_cnt = CFG.dly;
        end
        case (s.state)
            WPT_ST_IDLE:
            begin
                if (CFG.out_on)
                begin
                    case (CFG.mode)
                        WPT_MODE_CONT:
                        begin
                            if (CFG.cont_resp == WPT_CONT_FREE || trig)
                            begin
                                n.started = 1'b1;
                                n.state = WPT_ST_PLAY;
                            end
                        end
                        WPT_MODE_GATED:
                        begin
                            if (gate_act)
                            begin
                                n.started = 1'b1;
                                n.state = is_arb ? WPT_ST_PAUSE : WPT_ST_PLAY;
                            end
                        end
                        default:
                        begin
                            if (trig)
                            begin
                                n.started = 1'b1;
                                n.state = WPT_ST_PLAY;
                            end
                        end
                    endcase
                end
            end
            WPT_ST_PLAY:
            begin
                if (CFG.mode == WPT_MODE_GATED && is_arb && gate_act)
                    n.state = WPT_ST_PAUSE;
                else if (CFG.mode == WPT_MODE_GATED && CFG.data_kind == WPT_DATA_RT
                         && !gate_act)
                    n.state = WPT_ST_PAUSE;
                else
                begin
                    if (tick)
                    begin
                        n.i_live = SAMPLE.i;
                        n.q_live = SAMPLE.q;
                        n.mkr_live = SAMPLE.mkr & SEG.mkr_en;
                        n.off = off_nx;
                        if (end_seg)
                            n.seg = seg_nx;
                    end
                    case (CFG.mode)
                        WPT_MODE_SINGLE:
                        begin
                            if (trig && CFG.single_resp == WPT_RETRIG_ON)
                                n.pend = 1'b1;
                            if (tick && end_wave)
                            begin
                                n.pend = 1'b0;
                                if (!(CFG.single_resp == WPT_RETRIG_ON && (s.pend || trig)))
                                    n.state = WPT_ST_DONE;
                            end
                            if (trig && CFG.single_resp == WPT_RETRIG_IMM)
                            begin
                                n.off = '0;
                                n.seg = '0;
                                n.state = WPT_ST_PLAY;
                            end
                        end
                        WPT_MODE_SEG:
                        begin
                            if (trig)
                                n.pend = 1'b1;
                            if (tick && end_seg)
                            begin
                                n.pend = 1'b0;
                                if (!(s.pend || trig))
                                begin
                                    n.seg = s.seg;
                                    if (!CFG.seg_cont)
                                        n.state = WPT_ST_WAIT;
                                end
                            end
                        end
                        WPT_MODE_GATED:
                        begin
                            // stop only at an inactive frame end
                            if (is_fr && tick && end_seg && !gate_act)
                                n.state = WPT_ST_PAUSE;
                        end
                        WPT_MODE_CONT:
                        begin
                            // restart per trigger, stored data only
                            if (trig && CFG.cont_resp == WPT_CONT_RESET && is_arb)
                            begin
                                n.off = '0;
                                n.seg = '0;
                            end
                        end
                        default:
                            n.state = WPT_ST_IDLE;
                    endcase
                end
            end
            WPT_ST_PAUSE:
            begin
                if (is_arb)
                begin
                    if (!gate_act)
                        n.state = WPT_ST_PLAY;
                end
                // framed resumes on a frame boundary
                else if (gate_act && (!is_fr || s.off == '0))
                    n.state = WPT_ST_PLAY;
            end
            WPT_ST_WAIT:
            begin
                if (trig)
                begin
                    n.seg = seg_nx;
                    n.off = '0;
                    n.state = WPT_ST_PLAY;
                end
            end
            WPT_ST_DONE:
            begin
                if (trig)
                    n.state = WPT_ST_PLAY;
            end
            default:
                n.state = WPT_ST_IDLE;
        endcase
        if (reselect)
        begin
            n.state = WPT_ST_IDLE;
            n.started = 1'b0;
            n.pend = 1'b0;
            n.off = '0;
            n.seg = '0;
            n.i_live = '0;
            n.q_live = '0;
            n.mkr_live = '0;
            n.dly_busy = 1'b0;
        end
        // Markers pulse only during playback; I/Q keep final values
        if (n.state != WPT_ST_PLAY)
            n.mkr_live = '0;
        n.playing = (n.state == WPT_ST_PLAY);
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
            s <= `WPT_STATE_RST;
        else
            s <= n;
    end

    assign SEG_INDEX = s.seg;
    assign SAMPLE_ADDR = s.off;
    assign I_OUT = s.i_out;
    assign Q_OUT = s.q_out;
    assign EVENT_OUT = s.evt;
    assign RF_BLANK = s.blank;
    assign LEVEL_LOOP_HOLD = s.blank;
    assign PLAYING = s.playing;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RSTN);

    sequence seg_end_hit;
        s.state == WPT_ST_PLAY && CFG.mode == WPT_MODE_SEG && tick && end_seg && !reselect;
    endsequence

    sequence dly_arm;
        !s.dly_busy && raw_trig && use_dly && !reselect;
    endsequence

    chk_evt_pulse: assert property (
        s.mkr_live[0] && !CFG.mkr_neg[0] |=> EVENT_OUT[0])
        else $error("marker point gave no event pulse");
    chk_mkr_neg: assert property (
        s.mkr_live[0] && CFG.mkr_neg[0] |=> !EVENT_OUT[0])
        else $error("negative marker not inverted");
    chk_blank_low: assert property (
        CFG.mkr_blank_route[0] && (s.mkr_live[0] == CFG.mkr_neg[0])
        |=> RF_BLANK && LEVEL_LOOP_HOLD)
        else $error("low routed marker did not blank");
    chk_iq_zero: assert property (
        !s.started |=> (I_OUT == '0) && (Q_OUT == '0))
        else $error("iq not zero before first trigger");
    chk_single_done: assert property (
        s.state == WPT_ST_PLAY && CFG.mode == WPT_MODE_SINGLE
        && CFG.single_resp == WPT_RETRIG_OFF && tick && end_wave && !reselect
        |=> s.state == WPT_ST_DONE)
        else $error("single play did not stop at end");
    chk_immed_restart: assert property (
        s.state == WPT_ST_PLAY && CFG.mode == WPT_MODE_SINGLE
        && CFG.single_resp == WPT_RETRIG_IMM && trig && !reselect
        |=> s.state == WPT_ST_PLAY && s.off == '0 && s.seg == '0)
        else $error("immediate retrigger did not restart");
    chk_gate_freeze: assert property (
        s.state == WPT_ST_PLAY && CFG.mode == WPT_MODE_GATED && is_arb
        && gate_act && !reselect |=> s.state == WPT_ST_PAUSE && s.off == $past(s.off))
        else $error("gate active did not freeze playback");
    chk_dly_load: assert property (
        dly_arm |=> s.dly_busy && s.dly_cnt == $past(CFG.dly))
        else $error("trigger delay not loaded");
    chk_dly_discard: assert property (
        s.dly_busy && s.dly_cnt != '0 && !reselect
        |=> s.dly_busy && s.dly_cnt == $past(s.dly_cnt) - 1'b1)
        else $error("trigger during delay disturbed count");
    chk_free_start: assert property (
        s.state == WPT_ST_IDLE && CFG.out_on && CFG.mode == WPT_MODE_CONT
        && CFG.cont_resp == WPT_CONT_FREE && !reselect |=> s.state == WPT_ST_PLAY)
        else $error("free run did not start at once");
    chk_seg_wrap: assert property (
        seg_end_hit ##0 (last_seg && (s.pend || trig)) |=> s.seg == '0)
        else $error("last segment did not wrap to first");
    chk_seg_repeat: assert property (
        seg_end_hit ##0 (CFG.seg_cont && !s.pend && !trig)
        |=> s.state == WPT_ST_PLAY && s.seg == $past(s.seg))
        else $error("continuous segment did not repeat");

endmodule : wpt_play_ctrl

// ===== tb/wpt_far_end.sv
`timescale 1ns/1ps
`include "wpt_cfg.svh"
module wpt_far_end #(
    parameter logic [3:0] MKR_EN = 4'h3
) (
    input  wire logic [`WPT_SEG_W-1:0] seg_index,
    input  wire logic [`WPT_ADR_W-1:0] sample_addr,
    output wpt_pkg::wpt_seg_s          seg,
    output wpt_pkg::wpt_sample_s       sample
);
    import wpt_pkg::*;
    // Eight samples a segment, marker points on the first only
    always_comb
    begin
        seg.len_m1 = 16'h0007;
        seg.mkr_en = MKR_EN;
        // Offset by one so no played sample reads as zero
        sample.i   = {seg_index, sample_addr[11:0]} + 16'h0001;
        sample.q   = ~sample.i;
        sample.mkr = (sample_addr == 16'h0000) ? 4'hF : 4'h0;
    end
endmodule : wpt_far_end

// ===== tb/waveform_playback_trigger_control_test.sv
`timescale 1ns/1ps
`include "wpt_cfg.svh"
module waveform_playback_trigger_control_test;
    import wpt_pkg::*;
    logic                    sys_clk;
    logic                    rstn;
    wpt_cfg_s                cfg;
    wpt_cfg_s                base_cfg;
    wpt_cfg_s                next_cfg;
    logic                    wave_change;
    logic                    trig_key;
    logic                    trig_bus;
    logic                    ext1;
    logic                    ext2;
    wpt_seg_s                seg;
    wpt_sample_s             sample;
    logic [`WPT_SEG_W-1:0]   seg_index;
    logic [`WPT_SEG_W-1:0]   seg_seen;
    logic [`WPT_ADR_W-1:0]   sample_addr;
    logic [`WPT_IQ_W-1:0]    i_out;
    logic [`WPT_IQ_W-1:0]    q_out;
    logic [`WPT_MKR_N-1:0]   event_out;
    logic [`WPT_MKR_N-1:0]   ev_or;
    logic [`WPT_MKR_N-1:0]   ev_and;
    logic                    rf_blank;
    logic                    lvl_hold;
    logic                    playing;
    int                      hi;
    int                      bad;
    int                      fails = 0;
    int                      n_tests = 0;
    int                      cyc = 0;

    wpt_play_ctrl #(.SAMPLE_DIV(1)) u_wpt_play_ctrl (
        .SYS_CLK(sys_clk), .RSTN(rstn), .CFG(cfg), .WAVE_CHANGE(wave_change),
        .TRIG_KEY(trig_key), .TRIG_BUS(trig_bus), .EXT_TRIG_IN1(ext1),
        .EXT_TRIG_IN2(ext2), .SEG(seg), .SAMPLE(sample), .SEG_INDEX(seg_index),
        .SAMPLE_ADDR(sample_addr), .I_OUT(i_out), .Q_OUT(q_out),
        .EVENT_OUT(event_out), .RF_BLANK(rf_blank), .LEVEL_LOOP_HOLD(lvl_hold),
        .PLAYING(playing)
    );
    wpt_far_end u_wpt_far_end (
        .seg_index(seg_index), .sample_addr(sample_addr), .seg(seg), .sample(sample)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    // Nothing here should take more than a few hundred cycles
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    // Out_on low plus a new waveform, so every run starts from idle
    task automatic reselect;
        next_cfg.out_on = 1'b0;
        cfg = next_cfg;
        wave_change = 1'b1;
        tick(1);
        wave_change = 1'b0;
        cfg.out_on = 1'b1;
        tick(3);
    endtask : reselect

    task automatic watch(input int n, input int a, input int b);
        hi = 0;
        bad = 0;
        ev_or = '0;
        ev_and = '1;
        for (int c = 0; c < n; c++)
        begin
            trig_key = (c == a || c == b) && cfg.src == WPT_SRC_KEY;
            trig_bus = (c == a || c == b) && cfg.src == WPT_SRC_BUS;
            tick(1);
            hi += (playing === 1'b1);
            ev_or = ev_or | event_out;
            ev_and = ev_and & event_out;
            if (playing === 1'b1)
                seg_seen = seg_index;
            if (rf_blank !== ~event_out[0] || lvl_hold !== rf_blank)
                bad++;
        end
    endtask : watch

    task automatic t_single;
        for (int k = 0; k < 3; k++)
        begin
            next_cfg = base_cfg;
            next_cfg.single_resp = wpt_single_e'(k);
            next_cfg.src = (k == 1) ? WPT_SRC_BUS : WPT_SRC_KEY;
            reselect();
            check("iq before trigger", i_out, 16'h0000);
            watch(40, 0, (k == 0) ? 1 : 5);
            if (k == 0)
            begin
                check("single plays", 16'(hi), 16'h0008);
                check("final i", i_out, 16'h0008);
                check("final q", q_out, 16'hFFF7);
                check("marker pulses", 16'(ev_or), 16'h0003);
                check("marker lows", 16'(ev_and), 16'h0000);
                check("blanking", 16'(bad), 16'h0000);
                watch(20, 0, 99);
                check("replay after end", 16'(hi), 16'h0008);
            end
            else if (k == 1)
                check("queued replay", 16'(hi), 16'h0010);
            else
                check("restart length", 16'(hi > 8 && hi < 16), 16'h0001);
        end
    endtask : t_single

    task automatic t_cont;
        next_cfg = base_cfg;
        next_cfg.mode = WPT_MODE_CONT;
        reselect();
        watch(30, 3, 10);
        check("free run", 16'(hi > 27), 16'h0001);
        next_cfg.cont_resp = WPT_CONT_TRIG;
        reselect();
        watch(10, 99, 99);
        check("waits trigger", 16'(hi), 16'h0000);
        watch(40, 0, 20);
        check("runs on", 16'(hi > 36), 16'h0001);
        // Stored data restarts on the later trigger, real-time does not
        next_cfg.cont_resp = WPT_CONT_RESET;
        for (int k = 0; k < 2; k++)
        begin
            next_cfg.data_kind = wpt_data_e'(k);
            reselect();
            watch(12, 0, 5);
            check("reset run addr", sample_addr, (k == 0) ? 16'h0006 : 16'h0003);
        end
    endtask : t_cont

    task automatic t_ext(input logic pin2, input logic pos, input logic de);
        next_cfg = base_cfg;
        next_cfg.src = WPT_SRC_EXT;
        next_cfg.ext_pin2 = pin2;
        next_cfg.ext_pol_pos = pos;
        next_cfg.dly_en = de;
        next_cfg.dly = 16'h0014;
        ext1 = ~pos;
        ext2 = ~pos;
        reselect();
        if (pin2)
            ext2 = pos;
        else
            ext1 = pos;
        // Long enough that an undelayed trigger would already play
        if (de)
            watch(18, 99, 99);
        if (de)
            check("delay holds off", 16'(hi), 16'h0000);
        watch(30, 99, 99);
        check("one ext play", 16'(hi), 16'h0008);
    endtask : t_ext

    task automatic t_gate;
        next_cfg = base_cfg;
        next_cfg.mode = WPT_MODE_GATED;
        next_cfg.src = WPT_SRC_EXT;
        next_cfg.gate_high = 1'b1;
        ext1 = 1'b0;
        ext2 = 1'b0;
        reselect();
        watch(8, 99, 99);
        check("waits first gate", 16'(hi), 16'h0000);
        ext1 = 1'b1;
        watch(8, 99, 99);
        check("active pauses", 16'(hi), 16'h0000);
        ext1 = 1'b0;
        watch(10, 99, 99);
        check("inactive plays", 16'(hi > 4), 16'h0001);
        ext1 = 1'b1;
        watch(10, 99, 99);
        check("freezes", 16'(hi < 6), 16'h0001);
        // Real-time unframed sends while the low gate is active
        next_cfg.data_kind = WPT_DATA_RT;
        next_cfg.gate_high = 1'b0;
        ext1 = 1'b1;
        reselect();
        watch(8, 99, 99);
        check("rt waits gate", 16'(hi), 16'h0000);
        ext1 = 1'b0;
        watch(8, 99, 99);
        check("rt sends active", 16'(hi), 16'h0006);
        ext1 = 1'b1;
        watch(8, 99, 99);
        check("rt halts inactive", 16'(hi), 16'h0002);
    endtask : t_gate

    task automatic t_seg;
        next_cfg = base_cfg;
        next_cfg.mode = WPT_MODE_SEG;
        next_cfg.seg_last = 4'h1;
        reselect();
        for (int k = 0; k < 3; k++)
        begin
            watch(14, 0, 99);
            check("segment once", 16'(hi), 16'h0008);
            check("segment index", 16'(seg_seen), 16'(k % 2));
        end
        next_cfg.seg_cont = 1'b1;
        reselect();
        watch(30, 0, 12);
        check("repeats then runs", 16'(hi), 16'h001E);
        check("advanced segment", 16'(seg_index), 16'h0001);
        watch(12, 0, 99);
        check("wraps to first", 16'(seg_index), 16'h0000);
    endtask : t_seg

    initial
    begin
        base_cfg = '0;
        base_cfg.out_on = 1'b1;
        base_cfg.mkr_neg = 4'h2;
        base_cfg.mkr_blank_route = 4'h1;
        cfg = base_cfg;
        rstn = 1'b0;
        wave_change = 1'b0;
        trig_key = 1'b0;
        trig_bus = 1'b0;
        ext1 = 1'b1;
        ext2 = 1'b1;
        seg_seen = '0;
        tick(10);
        rstn = 1'b1;
        tick(2);
        t_single();
        t_cont();
        t_ext(1'b1, 1'b0, 1'b0);
        t_ext(1'b0, 1'b1, 1'b0);
        t_ext(1'b0, 1'b0, 1'b1);
        t_gate();
        t_seg();
        give_verdict();
    end
endmodule : waveform_playback_trigger_control_test
